//--- shared/sar_adc_pkg.sv
package sar_adc_pkg;
  // result width and lane width
  localparam int RESULT_W = 16;
  localparam int LANE_W = 8;
  // clock period and conversion timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_TIME_NS_X10 = 23; // 2.3 us typical conversion, in tenths of a microsecond
  localparam int CONV_CYCLES = (CONV_TIME_NS_X10 * 100000) / CLK_PERIOD_PS;
  localparam int STEP_CYCLES = CONV_CYCLES / RESULT_W;
  localparam int STEP_W = 16;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  // comparator interface: trial word out, decision back
  typedef struct packed {
    logic [RESULT_W-1:0] trial;
    logic sample_hold;
  } dac_drive_t;

  // data bus pin group
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic [RESULT_W-1:0] oe;
  } result_bus_t;
endpackage

//--- hdl/sar_adc_convert_read_port.sv
`timescale 1ns/1ps
// Operation
// - outputs float when select high or convert low
// - half-word low gives normal lane order
// - half-word high swaps the two lanes
// - convert falling with select low starts conversion
// - convert rising with select low enables outputs
// - select ORed; select falling with convert low starts
// - select falling with convert high enables outputs
// - busy low throughout conversion, high otherwise
// - result valid when busy rises
// - approximation register cleared at conversion start
// - starts ignored while conversion runs
// - trial word decided msb to lsb
// - final approximation copied to output latches
// - negative codes all-ones based near zero
// - result in two's complement
// - internal clock times conversion, 2.3 us
module sar_adc_convert_read_port
  import sar_adc_pkg::*;
#(
  parameter int STEP_COUNT = STEP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_i,
  input wire logic half_word_select_i,
  input wire logic comparator_above_i,
  output sar_adc_pkg::dac_drive_t dac_o,
  output sar_adc_pkg::result_bus_t result_bus_o,
  output logic busy_n_o
);
  import sar_adc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;

  conv_state_t state_reg, state_next;
  localparam int PIN_COUNT = 4;
  // synchroniser bank order: select, convert, half-word, comparator; select and convert idle high
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h3;
  logic [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_sync;
  logic cs_prev_reg, rc_prev_reg;
  logic [RESULT_W-1:0] approximation_register_reg;
  logic [RESULT_W-1:0] bit_mask_reg;
  logic [RESULT_W-1:0] latch_reg;
  logic [STEP_W-1:0] step_reg;
  logic [RESULT_W-1:0] bus_data_reg;
  logic bus_oe_reg;
  logic busy_n_reg;
  wire [RESULT_W-1:0] bus_select;

  // raw pin levels, one bit per synchroniser
  assign pin_raw = {comparator_above_i, half_word_select_i, read_convert_i, chip_select_n_i};

  // synchronised pin levels; only the second stage is read
  wire cs_n = pin_sync[0];
  wire rc = pin_sync[1];
  wire half_word = pin_sync[2];
  wire cmp_above = pin_sync[3];

  // read strobe: select low with convert high, and its previous level
  wire strobe_n = cs_n | ~rc;
  wire strobe_prev_n = cs_prev_reg | ~rc_prev_reg;
  // start is the low level of select ORed with convert, taken only while idle, so a host
  // that leaves both low when busy rises gets an immediate second conversion
  wire start_cond = ~(cs_n | rc);
  wire read_cond = ~strobe_n & strobe_prev_n;
  wire start = start_cond & (state_reg == ST_IDLE);
  // a step under three cycles would decide on a stale comparator level
  wire step_done = (step_reg == STEP_W'(STEP_COUNT - 1));
  wire last_bit = bit_mask_reg[0];
  wire converting = (state_reg == ST_CONV);
  wire finishing = (state_reg == ST_DONE);
  wire decide = converting & step_done;
  wire decide_last = decide & last_bit;
  wire drive_enable = ~strobe_n;
  wire [RESULT_W-1:0] msb_only = {1'b1, {(RESULT_W-1){1'b0}}};
  wire [RESULT_W-1:0] decided = cmp_above ? approximation_register_reg
                                          : approximation_register_reg & ~bit_mask_reg;
  wire [RESULT_W-1:0] next_trial = decided | (bit_mask_reg >> 1);
  // the search runs in offset binary; flipping the msb gives two's complement,
  // so mid-scale reads zero and the code just below it reads all ones
  wire [RESULT_W-1:0] result_code = decided ^ msb_only;

  // lane selection, one copy per byte lane of the result bus
  for (genvar lane = 0; lane < RESULT_W / LANE_W; lane++) begin : g_lane
    wire [LANE_W-1:0] own_lane = latch_reg[lane*LANE_W +: LANE_W];
    wire [LANE_W-1:0] other_lane = latch_reg[(RESULT_W/LANE_W-1-lane)*LANE_W +: LANE_W];
    assign bus_select[lane*LANE_W +: LANE_W] = half_word ? other_lane : own_lane;
  end

  // two-flop synchronisers for every pin input
  for (genvar pin = 0; pin < PIN_COUNT; pin++) begin : g_sync
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        meta_reg <= PIN_IDLE[pin];
        sync_reg <= PIN_IDLE[pin];
      end else if (ce_i) begin
        meta_reg <= pin_raw[pin];
        sync_reg <= meta_reg;
      end
    end
    assign pin_sync[pin] = sync_reg;
  end

  // previous synchronised levels for the read edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cs_prev_reg <= 1'b1;
      rc_prev_reg <= 1'b1;
    end else if (ce_i) begin
      cs_prev_reg <= cs_n;
      rc_prev_reg <= rc;
    end
  end

  // conversion sequencer state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_cond) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (step_done && last_bit) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // bit-time counter from the local clock, restarted at start and after each decision
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      step_reg <= '0;
    end else if (ce_i) begin
      if (start || decide) begin
        step_reg <= '0;
      end else if (converting) begin
        step_reg <= step_reg + STEP_W'(1);
      end
    end
  end

  // approximation register: cleared with the msb trial set, then one decision per bit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      approximation_register_reg <= RESULT_RESET;
    end else if (ce_i) begin
      if (start) begin
        approximation_register_reg <= msb_only;
      end else if (decide_last) begin
        approximation_register_reg <= decided;
      end else if (decide) begin
        approximation_register_reg <= next_trial;
      end
    end
  end

  // bit mask walks from the msb down to the lsb
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bit_mask_reg <= RESULT_RESET;
    end else if (ce_i) begin
      if (start) begin
        bit_mask_reg <= msb_only;
      end else if (decide) begin
        bit_mask_reg <= bit_mask_reg >> 1;
      end
    end
  end

  // output latch, loaded once from the final decision
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      latch_reg <= RESULT_RESET;
    end else if (ce_i) begin
      if (decide_last) begin
        latch_reg <= result_code;
      end
    end
  end

  // busy falls at start and rises the cycle after the latch load
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_n_reg <= 1'b1;
    end else if (ce_i) begin
      if (start) begin
        busy_n_reg <= 1'b0;
      end else if (finishing) begin
        busy_n_reg <= 1'b1;
      end
    end
  end

  // registered output drivers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bus_data_reg <= RESULT_RESET;
      bus_oe_reg <= 1'b0;
    end else if (ce_i) begin
      bus_data_reg <= bus_select;
      bus_oe_reg <= drive_enable & (read_cond | bus_oe_reg);
    end
  end

  // pin group and status outputs
  assign dac_o.trial = approximation_register_reg;
  assign dac_o.sample_hold = (state_reg != ST_IDLE); // hold while converting
  assign result_bus_o.data = bus_data_reg;
  assign result_bus_o.oe = {RESULT_W{bus_oe_reg}};
  assign busy_n_o = busy_n_reg;
endmodule

//--- testbench/sar_adc_asserts.sv
`timescale 1ns/1ps
module sar_adc_asserts
  import sar_adc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_i,
  input sar_adc_pkg::dac_drive_t dac_o,
  input sar_adc_pkg::result_bus_t result_bus_o,
  input wire logic busy_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // conversion start and a settled read request
  sequence s_start; $fell(busy_n_o); endsequence
  sequence s_read; (!chip_select_n_i && read_convert_i) [*5]; endsequence
  property p_float_cs; chip_select_n_i [*4] |-> result_bus_o.oe == 16'h0000; endproperty
  a_float_cs: assert property (p_float_cs) else $error("bus driven while deselected");
  property p_float_rc; !read_convert_i [*4] |-> result_bus_o.oe == 16'h0000; endproperty
  a_float_rc: assert property (p_float_rc) else $error("bus driven while convert low");
  property p_drive; s_read |-> result_bus_o.oe == 16'hffff; endproperty
  a_drive: assert property (p_drive) else $error("bus not driven on read");
  property p_oe_all; result_bus_o.oe == 16'h0000 || result_bus_o.oe == 16'hffff; endproperty
  a_oe_all: assert property (p_oe_all) else $error("lanes enabled unevenly");
  property p_busy_hold; s_start |-> !busy_n_o [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy ended early");
  property p_busy_end; s_start |-> ##[1:600] busy_n_o; endproperty
  a_busy_end: assert property (p_busy_end) else $error("conversion never ended");
  property p_clear; s_start |-> dac_o.trial == 16'h8000; endproperty
  a_clear: assert property (p_clear) else $error("trial word not cleared at start");
  property p_cause; s_start |-> $past(!chip_select_n_i && !read_convert_i, 2); endproperty
  a_cause: assert property (p_cause) else $error("conversion without start request");
  property p_hold; !busy_n_o |-> dac_o.sample_hold; endproperty
  a_hold: assert property (p_hold) else $error("sample not held while busy");
endmodule
bind sar_adc_convert_read_port sar_adc_asserts sar_adc_asserts_inst (.clock_i(clock_i), .rst_i(rst_i),
  .chip_select_n_i(chip_select_n_i), .read_convert_i(read_convert_i), .dac_o(dac_o),
  .result_bus_o(result_bus_o), .busy_n_o(busy_n_o));

//--- testbench/analog_side_model.sv
`timescale 1ns/1ps
module analog_side_model (
  input wire logic [15:0] trial_i,
  input wire logic [15:0] level_i,
  output logic above_o
);
  // keep the trial bit while the held level is at or above the trial word
  assign above_o = trial_i <= level_i;
endmodule

//--- testbench/sar_adc_convert_read_port_bench.sv
`timescale 1ns/1ps
module sar_adc_convert_read_port_bench;
  import sar_adc_pkg::*;
  logic clock_i = 0, rst_i = 1, cs_n = 1, rc = 1, hw = 0, ce = 1, above;
  logic [15:0] level = 16'h0000, e;
  logic [15:0] expq[$];
  dac_drive_t dac;
  result_bus_t bus;
  logic busy_n;
  int bad_count = 0, n_checks = 0, seed = 50699;
  always #2.5 clock_i = ~clock_i;
  // four cycles per bit: the comparator level needs three to pass its synchroniser
  sar_adc_convert_read_port #(.STEP_COUNT(4)) sar_adc_convert_read_port_inst (.clock_i(clock_i), .rst_i(rst_i),
    .ce_i(ce), .chip_select_n_i(cs_n), .read_convert_i(rc), .half_word_select_i(hw),
    .comparator_above_i(above), .dac_o(dac), .result_bus_o(bus), .busy_n_o(busy_n));
  analog_side_model analog_side_model_inst (.trial_i(dac.trial), .level_i(level), .above_o(above));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 300 && busy_n !== lvl; i++) @(negedge clock_i);
    if (busy_n !== lvl) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // boundary codes then random levels, alternating start modes
  initial begin
    cyc(10);
    rst_i = 0;
    for (int k = 0; k < 6; k++) begin
      level = k < 4 ? {k[0], {15{k[1]}}} : 16'($random(seed));
      expq.push_back(level);
      hw = k[1];
      if (k[0]) rc = 0;
      else cs_n = 0;
      cyc(2);
      cs_n = 0;
      rc = 0;
      cyc(8);
      rc = 1;
      cs_n = k[0];
      chk("busy", {15'h0000, busy_n}, 16'h0000);
      chk("hold", {15'h0000, dac.sample_hold}, 16'h0001);
      if (k == 3) begin
        ce = 0;
        e = dac.trial;
        cyc(20);
        chk("freeze", dac.trial, e);
        chk("frozen busy", {15'h0000, busy_n}, 16'h0000);
        ce = 1;
      end
      if (k == 2) begin
        rc = 0;
        cyc(8);
        rc = 1;
      end
      wait_busy(1);
      cs_n = 0;
      cyc(5);
      e = expq.pop_front() ^ 16'h8000; // offset-binary level read back as two's complement
      chk("oe", bus.oe, 16'hffff);
      chk("data", bus.data, hw ? {e[7:0], e[15:8]} : e);
      hw = ~hw;
      cyc(5);
      chk("swap", bus.data, hw ? {e[7:0], e[15:8]} : e);
      cs_n = 1;
      cyc(5);
      chk("float", bus.oe, 16'h0000);
      cyc(300);
      $display("test %0d done", k);
    end
    end_of_test();
  end
endmodule
